// File: hw/fhs_pkg.sv
// Package of constants and types for the fault hiccup sequencer
package fhs_pkg;

  // Register bus geometry
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFS      = 8'h00;
  localparam logic [7:0] STATUS_OFS    = 8'h04;
  localparam logic [7:0] IRQ_STAT_OFS  = 8'h08;
  localparam logic [7:0] IRQ_MASK_OFS  = 8'h0C;
  localparam logic [7:0] RETRY_CNT_OFS = 8'h10;

  // Control register fields
  localparam int unsigned CTRL_RUN_BIT = 0;
  localparam logic        CTRL_RUN_RST = 1'b1;

  // Status register fields
  localparam int unsigned ST_STATE_LSB  = 0;
  localparam int unsigned ST_OUTPUT_OK_FLAG_BIT  = 4;
  localparam int unsigned ST_ENABLE_BIT = 5;
  localparam int unsigned ST_OC_BIT     = 6;
  localparam int unsigned ST_OPEN_BIT   = 7;

  // Interrupt event bits, same layout in status and mask
  localparam int unsigned EV_W         = 4;
  localparam int unsigned EV_OC_BIT    = 0;
  localparam int unsigned EV_OPEN_BIT  = 1;
  localparam int unsigned EV_SSOK_BIT  = 2;
  localparam int unsigned EV_PGLOW_BIT = 3;
  localparam logic [EV_W-1:0] IRQ_MASK_RST = 4'h0;

  // Timing in switching cycles
  localparam int unsigned SS_DELAY_CYC = 64;
  localparam int unsigned OC_WAIT_CYC  = 4096;
  localparam int unsigned CNT_W        = 13;
  localparam int unsigned RETRY_W      = 16;

  // Sequencer states
  typedef enum logic [2:0] {
    FHS_SHUTDOWN = 3'b000,
    FHS_SS_DELAY = 3'b001,
    FHS_SS_RAMP  = 3'b010,
    FHS_RUN      = 3'b011,
    FHS_OC_WAIT  = 3'b100,
    FHS_OPEN     = 3'b101
  } fhs_state_e;

endpackage

// File: hw/fhs_fault_hiccup_sequencer.sv
// Fault hiccup sequencer: open-sense and overcurrent handling of a buck
// What this block does
// - Shut the converter down while the open-sense flag is high.
// - When open-sense clears, restart from the very start of soft-start.
// - Enter overcurrent protection while the overcurrent flag is high.
// - On overcurrent, command upper and lower gate drives of all phases off.
// - Hold drivers off for exactly 4096 switching cycles.
// - After the wait, start a new soft-start if still enabled.
// - Repeat trip, wait and retry without limit until disabled or cleared.
// - Pull power-good low on undervoltage, overvoltage, overcurrent or disable.
// - Each soft-start waits 64 switching cycles before the ramp starts.
// - In shutdown keep pulse-width outputs high impedance.
//
// Local design decisions: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module fhs_fault_hiccup_sequencer
  import fhs_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              reset_n,
  // Register port
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DATA_W-1:0] reg_rdata,
  output logic                   irq,
  // Condition inputs
  input  wire logic              sw_cycle_tick,
  input  wire logic              threshold_enable_input,
  input  wire logic              driver_supply_ok,
  input  wire logic              open_sense_flag,
  input  wire logic              overcurrent_flag,
  input  wire logic              undervoltage_flag,
  input  wire logic              overvoltage_flag,
  input  wire logic              ramp_done,
  // Outputs to soft-start ramp and gate drivers
  output logic                   ss_restart,
  output logic                   ramp_enable,
  output logic                   pwm_hiz,
  output logic                   upper_gate_off,
  output logic                   lower_gate_off,
  // Open-drain power-good pin
  input  wire logic              output_ok_flag_in,
  output logic                   output_ok_flag_out,
  output logic                   output_ok_flag_oe
);

  // Reset synchroniser
  logic rst_meta_reg;
  logic rst_sync_reg;

  // Sequencer state and counters
  fhs_state_e          state_reg;
  fhs_state_e          state_next;
  logic [CNT_W-1:0]    cnt_reg;
  logic [CNT_W-1:0]    cnt_next;
  logic [RETRY_W-1:0]  retry_reg;

  // Software registers
  logic                run_reg;
  logic [EV_W-1:0]     irq_stat_reg;
  logic [EV_W-1:0]     irq_mask_reg;
  logic [EV_W-1:0]     ev_set;
  logic                pg_good_reg;
  logic                pg_good_next;

  // Derived conditions
  logic enabled;
  logic cnt_done;
  logic oc_enter;
  logic open_enter;
  logic ss_enter;

  // Decode of a register offset
  function automatic logic addr_is(input logic [ADDR_W-1:0] a,
                                   input logic [7:0]        ofs);
    addr_is = (a == ofs);
  endfunction

  // Two-stage release of the asynchronous reset; assertion stays
  // asynchronous so the bridge goes off even with the clock stopped
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  // Enable needs the enable pin, supply reset and software run bit
  assign enabled = threshold_enable_input & driver_supply_ok & run_reg;

  // Terminal count of the current wait in switching cycles
  always_comb begin
    cnt_done = 1'b0;
    if (state_reg == FHS_SS_DELAY) begin
      cnt_done = sw_cycle_tick &
                 (cnt_reg == CNT_W'(SS_DELAY_CYC - 1));
    end else if (state_reg == FHS_OC_WAIT) begin
      cnt_done = sw_cycle_tick &
                 (cnt_reg == CNT_W'(OC_WAIT_CYC - 1));
    end
  end

  // Next-state logic; disable first, then open sense, then overcurrent
  // Overcurrent is ignored in shutdown and open, the bridge is off there
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      FHS_SHUTDOWN: begin
        if (enabled && !open_sense_flag) begin
          state_next = FHS_SS_DELAY;
        end
      end
      FHS_SS_DELAY: begin
        if (!enabled) begin
          state_next = FHS_SHUTDOWN;
        end else if (open_sense_flag) begin
          state_next = FHS_OPEN;
        end else if (overcurrent_flag) begin
          state_next = FHS_OC_WAIT;
        end else if (cnt_done) begin
          state_next = FHS_SS_RAMP;
        end
      end
      FHS_SS_RAMP: begin
        if (!enabled) begin
          state_next = FHS_SHUTDOWN;
        end else if (open_sense_flag) begin
          state_next = FHS_OPEN;
        end else if (overcurrent_flag) begin
          state_next = FHS_OC_WAIT;
        end else if (ramp_done) begin
          state_next = FHS_RUN;
        end
      end
      FHS_RUN: begin
        if (!enabled) begin
          state_next = FHS_SHUTDOWN;
        end else if (open_sense_flag) begin
          state_next = FHS_OPEN;
        end else if (overcurrent_flag) begin
          state_next = FHS_OC_WAIT;
        end
      end
      FHS_OC_WAIT: begin
        if (!enabled) begin
          state_next = FHS_SHUTDOWN;
        end else if (open_sense_flag) begin
          state_next = FHS_OPEN;
        end else if (cnt_done) begin
          state_next = FHS_SS_DELAY;
        end
      end
      FHS_OPEN: begin
        if (!enabled) begin
          state_next = FHS_SHUTDOWN;
        end else if (!open_sense_flag) begin
          state_next = FHS_SS_DELAY;
        end
      end
      default: begin
        state_next = FHS_SHUTDOWN;
      end
    endcase
  end

  // Entry events
  assign oc_enter   = (state_next == FHS_OC_WAIT) &&
                      (state_reg != FHS_OC_WAIT);
  assign open_enter = (state_next == FHS_OPEN) &&
                      (state_reg != FHS_OPEN);
  assign ss_enter   = (state_next == FHS_SS_DELAY) &&
                      (state_reg != FHS_SS_DELAY);

  // State register
  always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      state_reg <= FHS_SHUTDOWN;
    end else begin
      state_reg <= state_next;
    end
  end

  // Wait counter: cleared on every state change, counts switching cycles
  always_comb begin
    cnt_next = cnt_reg;
    if (state_next != state_reg) begin
      cnt_next = '0;
    end else if (sw_cycle_tick) begin
      cnt_next = cnt_reg + CNT_W'(1);
    end
  end

  // Counter register
  always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  // Count of overcurrent trips, saturating
  always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      retry_reg <= '0;
    end else if (oc_enter && (retry_reg != '1)) begin
      retry_reg <= retry_reg + RETRY_W'(1);
    end
  end

  // Driver commands, all registered
  // Taken from the next state so the outputs move on the state's edge
  always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      pwm_hiz        <= 1'b1;
      upper_gate_off <= 1'b1;
      lower_gate_off <= 1'b1;
      ramp_enable    <= 1'b0;
      ss_restart     <= 1'b0;
    end else begin
      // Outputs stay floating outside ramp and run
      pwm_hiz <= (state_next != FHS_SS_RAMP) &&
                 (state_next != FHS_RUN);
      // Both gates forced off while not switching
      upper_gate_off <= (state_next != FHS_SS_RAMP) &&
                        (state_next != FHS_RUN);
      lower_gate_off <= (state_next != FHS_SS_RAMP) &&
                        (state_next != FHS_RUN);
      ramp_enable <= (state_next == FHS_SS_RAMP) ||
                     (state_next == FHS_RUN);
      ss_restart  <= ss_enter;
    end
  end

  // Power-good: high only in run with no voltage or current fault
  assign pg_good_next = (state_next == FHS_RUN) &&
                        !undervoltage_flag && !overvoltage_flag &&
                        !overcurrent_flag;

  always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      pg_good_reg        <= 1'b0;
      output_ok_flag_out <= 1'b0;
      output_ok_flag_oe  <= 1'b1;
    end else begin
      pg_good_reg        <= pg_good_next;
      output_ok_flag_out <= 1'b0;
      output_ok_flag_oe  <= !pg_good_next;
    end
  end

  // Interrupt events
  always_comb begin
    ev_set               = '0;
    ev_set[EV_OC_BIT]    = oc_enter;
    ev_set[EV_OPEN_BIT]  = open_enter;
    ev_set[EV_SSOK_BIT]  = (state_next == FHS_RUN) &&
                           (state_reg == FHS_SS_RAMP);
    ev_set[EV_PGLOW_BIT] = pg_good_reg && !pg_good_next;
  end

  // Sticky status, write one to clear, a new event wins over the clear
  // so an event landing on the clearing write is never lost
  always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      irq_stat_reg <= '0;
    end else begin
      for (int i = 0; i < EV_W; i++) begin
        if (ev_set[i]) begin
          irq_stat_reg[i] <= 1'b1;
        end else if (reg_wr && addr_is(reg_addr, IRQ_STAT_OFS) &&
                     reg_wdata[i]) begin
          irq_stat_reg[i] <= 1'b0;
        end
      end
    end
  end

  // Control and mask registers
  always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      run_reg      <= CTRL_RUN_RST;
      irq_mask_reg <= IRQ_MASK_RST;
    end else if (reg_wr) begin
      if (addr_is(reg_addr, CTRL_OFS)) begin
        run_reg <= reg_wdata[CTRL_RUN_BIT];
      end
      if (addr_is(reg_addr, IRQ_MASK_OFS)) begin
        irq_mask_reg <= reg_wdata[EV_W-1:0];
      end
    end
  end

  // Level interrupt from unmasked sticky bits
  always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // Read data one cycle after the strobe, zero elsewhere
  always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= '0;
      if (reg_rd) begin
        if (addr_is(reg_addr, CTRL_OFS)) begin
          reg_rdata[CTRL_RUN_BIT] <= run_reg;
        end else if (addr_is(reg_addr, STATUS_OFS)) begin
          reg_rdata[ST_STATE_LSB +: $bits(fhs_state_e)] <= state_reg;
          reg_rdata[ST_OUTPUT_OK_FLAG_BIT]      <= pg_good_reg;
          reg_rdata[ST_ENABLE_BIT]     <= enabled;
          reg_rdata[ST_OC_BIT]         <= overcurrent_flag;
          reg_rdata[ST_OPEN_BIT]       <= open_sense_flag;
        end else if (addr_is(reg_addr, IRQ_STAT_OFS)) begin
          reg_rdata[EV_W-1:0] <= irq_stat_reg;
        end else if (addr_is(reg_addr, IRQ_MASK_OFS)) begin
          reg_rdata[EV_W-1:0] <= irq_mask_reg;
        end else if (addr_is(reg_addr, RETRY_CNT_OFS)) begin
          reg_rdata[RETRY_W-1:0] <= retry_reg;
        end
      end
    end
  end

  // Pin readback is not used: power-good follows state and fault flags,
  // so a wired-low neighbour on the pin cannot hold off a restart
  logic unused_pin;
  assign unused_pin = output_ok_flag_in;

endmodule

`default_nettype wire

// File: tb/fhs_checker.sv
// Port-level assertions for the fault hiccup sequencer
`timescale 1ns/1ps
`default_nettype none
module fhs_checker (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic threshold_enable_input,
  input wire logic open_sense_flag,
  input wire logic overcurrent_flag,
  input wire logic undervoltage_flag,
  input wire logic overvoltage_flag,
  input wire logic ss_restart,
  input wire logic ramp_enable,
  input wire logic pwm_hiz,
  input wire logic upper_gate_off,
  input wire logic lower_gate_off,
  input wire logic output_ok_flag_out,
  input wire logic output_ok_flag_oe
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // A restart opens a delay with the bridge released
  sequence restart_seq;
    ss_restart;
  endsequence
  sequence delay_seq;
    (pwm_hiz && !ramp_enable) [*8];
  endsequence
  // Trip, shutdown and power-good relations
  oc_trip_off_a: assert property (
    overcurrent_flag && ramp_enable |=>
    upper_gate_off && lower_gate_off && !ramp_enable)
    else $error("gates not forced off after overcurrent");
  drive_match_a: assert property (
    pwm_hiz == upper_gate_off && pwm_hiz == lower_gate_off &&
    pwm_hiz == !ramp_enable)
    else $error("gate and high impedance outputs disagree");
  open_shut_a: assert property (
    open_sense_flag |=> pwm_hiz && output_ok_flag_oe)
    else $error("open sense did not shut down");
  disable_pg_a: assert property (
    !threshold_enable_input |=> output_ok_flag_oe && pwm_hiz)
    else $error("disable did not pull power good low");
  fault_pg_a: assert property (
    undervoltage_flag || overvoltage_flag || overcurrent_flag
    |=> output_ok_flag_oe)
    else $error("fault did not pull power good low");
  delay_hold_a: assert property (
    restart_seq |-> delay_seq)
    else $error("bridge active early in soft-start delay");
  restart_pulse_a: assert property (
    ss_restart |=> !ss_restart)
    else $error("restart pulse longer than one cycle");
  pg_rise_a: assert property (
    $fell(output_ok_flag_oe) |-> ramp_enable && !pwm_hiz)
    else $error("power good released outside run");
  drain_zero_a: assert property (
    output_ok_flag_out == 1'b0)
    else $error("power good pin driven high");
endmodule
`default_nettype wire

// File: tb/fhs_ramp_model.sv
// Behavioural soft-start ramp partner for the sequencer
`timescale 1ns/1ps
`default_nettype none
module fhs_ramp_model (
  input  wire logic       ref_clk,
  input  wire logic       reset_n,
  input  wire logic       ss_restart,
  input  wire logic       ramp_enable,
  input  wire logic [7:0] ramp_len,
  output logic            ramp_done
);
  logic [7:0] step_reg;
  // Ramp climbs only while enabled, restarts from zero on request
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      step_reg  <= 8'h00;
      ramp_done <= 1'b0;
    end else if (ss_restart) begin
      step_reg  <= 8'h00;
      ramp_done <= 1'b0;
    end else if (ramp_enable && !ramp_done) begin
      step_reg  <= step_reg + 8'h01;
      ramp_done <= (step_reg + 8'h01 >= ramp_len);
    end
  end
endmodule
`default_nettype wire

// File: tb/tb_top.sv
// Directed testbench for the fault hiccup sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import fhs_pkg::*;
();
  logic              ref_clk = 1'b0, reset_n = 1'b0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0, reg_rdata, v;
  logic              reg_wr = 1'b0, reg_rd = 1'b0, irq, seen;
  logic              sw_cycle_tick = 1'b1, driver_supply_ok = 1'b1;
  logic              threshold_enable_input = 1'b0, open_sense_flag = 1'b0;
  logic              overcurrent_flag = 1'b0, undervoltage_flag = 1'b0;
  logic              overvoltage_flag = 1'b0, ramp_done, ss_restart;
  logic              ramp_enable, pwm_hiz, upper_gate_off, lower_gate_off;
  logic              output_ok_flag_out, output_ok_flag_oe;
  logic [7:0]        ramp_len = 8'h14;
  int                n, n_mismatch = 0, total_checks = 0;
  wire logic         pg_pin = !output_ok_flag_oe;
  // Clock and design under test with its ramp partner
  always #25 ref_clk = ~ref_clk;
  fhs_fault_hiccup_sequencer dut (.ref_clk, .reset_n, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .irq, .sw_cycle_tick,
    .threshold_enable_input, .driver_supply_ok, .open_sense_flag,
    .overcurrent_flag, .undervoltage_flag, .overvoltage_flag, .ramp_done,
    .ss_restart, .ramp_enable, .pwm_hiz, .upper_gate_off, .lower_gate_off,
    .output_ok_flag_in(pg_pin), .output_ok_flag_out, .output_ok_flag_oe);
  fhs_ramp_model ramp (.ref_clk, .reset_n, .ss_restart, .ramp_enable,
    .ramp_len, .ramp_done);
  // Compare, bus and wait helpers
  task automatic check(input string what, input logic [31:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  function automatic logic sig(input int s);
    case (s)
      0: sig = ss_restart;
      1: sig = ramp_enable;
      default: sig = !output_ok_flag_oe;
    endcase
  endfunction
  task automatic wait_on(input int s);
    n = 0;
    while (sig(s) !== 1'b1) begin
      @(posedge ref_clk);
      #1 n++;
      if (n > 5000) begin
        n_mismatch++;
        summarize();
      end
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rd(CTRL_OFS);
    check("ctrl reset", v, 32'h0000_0001);
    rd(IRQ_MASK_OFS);
    check("mask reset", v, 32'h0000_0000);
    rd(8'h20);
    check("unmapped", v, 32'h0000_0000);
    wr(IRQ_MASK_OFS, 32'h0000_000F);
    threshold_enable_input <= 1'b1;
    #1 wait_on(0);
    wait_on(1);
    check("delay cycles", n, SS_DELAY_CYC);
    wait_on(2);
    rd(STATUS_OFS);
    check("run status", v, 32'h0000_0033);
    $display("test startup done");
    @(posedge ref_clk);
    overcurrent_flag <= 1'b1;
    @(posedge ref_clk);
    #1 check("gates off", {upper_gate_off, lower_gate_off}, 2'b11);
    check("pg on oc", output_ok_flag_oe, 1'b1);
    wait_on(0);
    check("oc wait", n, OC_WAIT_CYC);
    @(posedge ref_clk);
    overcurrent_flag <= 1'b0;
    #1 wait_on(0);
    check("retry wait", n, OC_WAIT_CYC);
    rd(RETRY_CNT_OFS);
    check("trip count", v, 32'h0000_0002);
    rd(IRQ_STAT_OFS);
    check("oc event", v[EV_OC_BIT], 1'b1);
    check("irq on", irq, 1'b1);
    wait_on(2);
    wr(IRQ_STAT_OFS, 32'h0000_000F);
    rd(IRQ_STAT_OFS);
    check("events cleared", v, 32'h0000_0000);
    check("irq off", irq, 1'b0);
    $display("test overcurrent done");
    wr(IRQ_MASK_OFS, 32'h0000_0000);
    for (int i = 0; i < 2; i++) begin
      {overvoltage_flag, undervoltage_flag} <= 2'(i + 1);
      repeat (2) @(posedge ref_clk);
      #1 check("pg on fault", output_ok_flag_oe, 1'b1);
      check("irq masked", irq, 1'b0);
      @(posedge ref_clk);
      {overvoltage_flag, undervoltage_flag} <= 2'b00;
      #1 wait_on(2);
      @(posedge ref_clk);
    end
    wr(IRQ_MASK_OFS, 32'h0000_0008);
    repeat (2) @(posedge ref_clk);
    #1 check("irq unmasked", irq, 1'b1);
    wr(IRQ_STAT_OFS, 32'h0000_000F);
    $display("test power good done");
    overcurrent_flag <= 1'b1;
    repeat (3) @(posedge ref_clk);
    threshold_enable_input <= 1'b0;
    overcurrent_flag <= 1'b0;
    seen = 1'b0;
    repeat (4200) begin
      @(posedge ref_clk);
      #1 seen |= ss_restart;
    end
    check("no retry", seen, 1'b0);
    rd(STATUS_OFS);
    check("shutdown", v[2:0], FHS_SHUTDOWN);
    $display("test disable done");
    @(posedge ref_clk);
    ramp_len <= 8'h01;
    threshold_enable_input <= 1'b1;
    #1 wait_on(2);
    @(posedge ref_clk);
    open_sense_flag <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1 check("open hiz", pwm_hiz, 1'b1);
    rd(STATUS_OFS);
    check("open state", v[2:0], FHS_OPEN);
    rd(IRQ_STAT_OFS);
    check("open event", v[EV_OPEN_BIT], 1'b1);
    @(posedge ref_clk);
    open_sense_flag <= 1'b0;
    #1 wait_on(0);
    check("open restart", n, 1);
    wait_on(1);
    check("full delay", n, SS_DELAY_CYC);
    $display("test open sense done");
    @(posedge ref_clk);
    driver_supply_ok <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rd(STATUS_OFS);
    check("supply off", v, 32'h0000_0000);
    wr(CTRL_OFS, 32'h0000_0000);
    driver_supply_ok <= 1'b1;
    rd(STATUS_OFS);
    check("run bit off", v, 32'h0000_0000);
    $display("test supply and run bit done");
    summarize();
  end
endmodule
bind fhs_fault_hiccup_sequencer fhs_checker chk (.ref_clk, .reset_n,
  .threshold_enable_input, .open_sense_flag, .overcurrent_flag,
  .undervoltage_flag, .overvoltage_flag, .ss_restart, .ramp_enable,
  .pwm_hiz, .upper_gate_off, .lower_gate_off, .output_ok_flag_out,
  .output_ok_flag_oe);
`default_nettype wire
